// ===== hdl/sync_serial_port_consts.vh
// Register offsets, field positions, reset values and timing constants of the synchronous serial port.
`ifndef SYNC_SERIAL_PORT_CONSTS_VH
`define SYNC_SERIAL_PORT_CONSTS_VH

`define SSP_ADDR_W 8
`define SSP_OFF_STATUS 8'h10
`define SSP_OFF_CONTROL 8'h12
`define SSP_OFF_TX_ONE 8'h14
`define SSP_OFF_TX_ZERO 8'h16
`define SSP_OFF_RX 8'h18

`define SSP_STAT_BUSY 0
`define SSP_STAT_DONE 1
`define SSP_STAT_COLL 2

`define SSP_CTL_SEL0 0
`define SSP_CTL_SEL1 1
`define SSP_CTL_DIV_LO 4
`define SSP_CTL_DIV_HI 5

`define SSP_CTL_RESET 1'h0
`define SSP_DIV_RESET 2'h0
`define SSP_CTL_RSVD_HI 10'h3ff

`define SSP_WORD_BITS 8
`define SSP_BIT_CNT_LAST 3'h7
`define SSP_DIV_CNT_W 3

`endif

// ===== hdl/sync_serial_port.v
// Synchronous serial master port with two peripheral selects, a shift clock and a shared data line.
// How it works
// - Device always masters clock and selects
// - Four pins: two selects, clock, data
// - Only one party drives data line
// - Two peripheral select outputs; select one is blocked while select zero is set
// - Shift clock is processor clock divided
// - Shift clock toggles only during transfers
// - Divider follows slowed processor clock
// - Drive on falling, sample on rising
// - Words go least significant bit first
// - Last written bit held half period
// - Weak keeper holds last data level
// - Two transmit registers share data line
// - Busy flag in status bit 0
// - Tx write or rx read while busy sets collision flag
// - Collision cleared when both selects off
// - Done set at rising edge, bit 7
// - Done cleared by rx, tx, deselect
// - Status read clears done; set wins
// - Status read-only, reset zero, upper zero
// - Transmit write starts; busy write collides
// - Rx read starts receive if selected
// - Select bits drive pins; zero wins
// - Divider codes 2, 4, 8, 16
`timescale 1ns/10ps
`default_nettype none
`include "sync_serial_port_consts.vh"

module sync_serial_port #(
    parameter WORD_BITS = `SSP_WORD_BITS
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [`SSP_ADDR_W-1:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rdata_o,
    output wire periph_select_zero_o,
    output wire periph_select_one_o,
    output reg shift_clock_o,
    input wire shared_data_line_i,
    output reg shared_data_line_o,
    output reg shared_data_line_oe_o
);

    // ==========================================================
    // Local state codes
    // ==========================================================
    // Only a write has a tail state; a receive goes straight back to idle.
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SHIFT = 2'h1;
    localparam [1:0] ST_TAIL = 2'h2;

    // ==========================================================
    // Registers
    // ==========================================================
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg sel0_en_r;
    reg sel1_en_r;
    reg [1:0] div_r;
    reg [7:0] tx_one_r;
    reg [7:0] tx_zero_r;
    reg [7:0] rx_r;
    reg [7:0] shift_r;
    reg dir_tx_r;
    reg [2:0] bit_cnt_r;
    reg [`SSP_DIV_CNT_W-1:0] half_cnt_r;
    reg done_r;
    reg coll_r;
    reg data_s1_r;
    reg data_s2_r;

    // Refused accesses are still decoded here so that the collision flag can see them.
    wire busy = (state_r != ST_IDLE);
    wire any_sel = sel0_en_r | sel1_en_r;
    wire wr_tx = wr_i && ((addr_i == `SSP_OFF_TX_ONE) || (addr_i == `SSP_OFF_TX_ZERO));
    wire rd_rx = rd_i && (addr_i == `SSP_OFF_RX);
    wire rd_stat = rd_i && (addr_i == `SSP_OFF_STATUS);
    wire start_tx = wr_tx && !busy;
    wire start_rx = rd_rx && !busy && any_sel;

    // Half-period length in processor clocks: 1, 2, 4 or 8 for divide by 2, 4, 8, 16.
    reg [`SSP_DIV_CNT_W-1:0] half_last;
    always @* begin
        case (div_r)
            2'h0: half_last = 3'h0;
            2'h1: half_last = 3'h1;
            2'h2: half_last = 3'h3;
            default: half_last = 3'h7;
        endcase
    end

    // The divider runs on the processor clock itself, so a slowed clock slows the link too.
    wire half_tick = (half_cnt_r == half_last);

    // ==========================================================
    // Select outputs
    // ==========================================================
    // A select pin is granted only when no lower-numbered enable is set, so two peripherals never
    // see themselves addressed at once on the shared clock and data lines.
    wire [1:0] sel_en = {sel1_en_r, sel0_en_r};
    wire [1:0] sel_pin;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_sel
            if (g == 0) begin : g_first
                assign sel_pin[g] = sel_en[g];
            end else begin : g_rest
                assign sel_pin[g] = sel_en[g] & ~(|sel_en[g-1:0]);
            end
        end
    endgenerate

    // The port only ever drives these pins, it never listens to them.
    assign periph_select_zero_o = sel_pin[0];
    assign periph_select_one_o = sel_pin[1];

    // ==========================================================
    // Data line input synchroniser
    // ==========================================================
    // The line is an outside pin, so it passes two flops; a read therefore sees the slave's bit
    // two processor clocks late, which rules out the two fastest dividers, 2 and 4, for receive transfers.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            data_s1_r <= 1'b0;
            data_s2_r <= 1'b0;
        end else begin
            data_s1_r <= shared_data_line_i;
            data_s2_r <= data_s1_r;
        end
    end

    // ==========================================================
    // Shift clock edge strobes
    // ==========================================================
    // A divider tick while the clock is high is a falling edge, while it is low a rising edge.
    wire in_shift = (state_r == ST_SHIFT);
    wire fall_edge = in_shift && half_tick && shift_clock_o;
    wire rise_edge = in_shift && half_tick && !shift_clock_o;
    wire last_rise = rise_edge && (bit_cnt_r == `SSP_BIT_CNT_LAST);

    // ==========================================================
    // Transfer sequencer
    // ==========================================================
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_tx || start_rx) begin
                    state_nxt = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                // A receive ends on the last rising edge; a write still has its tail to run.
                if (last_rise) begin
                    state_nxt = dir_tx_r ? ST_TAIL : ST_IDLE;
                end
            end
            ST_TAIL: begin
                if (half_tick) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Half-period divider and shift clock
    // ==========================================================
    // The count restarts at every start so the first falling edge comes a full half period later.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            half_cnt_r <= 3'h0;
        end else if (!busy || half_tick) begin
            half_cnt_r <= 3'h0;
        end else begin
            half_cnt_r <= half_cnt_r + 3'h1;
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            shift_clock_o <= 1'b1;
        end else if (!busy) begin
            shift_clock_o <= 1'b1;
        end else if (in_shift && half_tick) begin
            shift_clock_o <= ~shift_clock_o;
        end
    end

    // ==========================================================
    // Bit counter and shift register
    // ==========================================================
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            bit_cnt_r <= 3'h0;
        end else if (!busy) begin
            bit_cnt_r <= 3'h0;
        end else if (rise_edge) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            dir_tx_r <= 1'b0;
        end else if (start_tx) begin
            dir_tx_r <= 1'b1;
        end else if (start_rx) begin
            dir_tx_r <= 1'b0;
        end
    end

    // Both transmit registers feed the one shift register; only the low byte of a write is sent.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            shift_r <= 8'h00;
        end else if (start_tx) begin
            shift_r <= wdata_i[7:0];
        end else if (rise_edge) begin
            // The line is taken on the rising edge and the word moves one place towards bit 0.
            shift_r <= {data_s2_r, shift_r[7:1]};
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            rx_r <= 8'h00;
        end else if (last_rise && !dir_tx_r) begin
            rx_r <= {data_s2_r, shift_r[7:1]};
        end
    end

    // ==========================================================
    // Data line driver
    // ==========================================================
    // The enable drops only after the tail, so the last written bit stands a further half period.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            shared_data_line_oe_o <= 1'b0;
        end else if (!busy) begin
            shared_data_line_oe_o <= 1'b0;
        end else if (fall_edge) begin
            shared_data_line_oe_o <= dir_tx_r;
        end else if (state_r == ST_TAIL && half_tick) begin
            shared_data_line_oe_o <= 1'b0;
        end
    end

    // On release the output value is left as it was; the pad keeper then holds the line level.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            shared_data_line_o <= 1'b0;
        end else if (fall_edge && dir_tx_r) begin
            shared_data_line_o <= shift_r[0];
        end
    end

    wire done_set = last_rise;

    // ==========================================================
    // Software registers and flags
    // ==========================================================
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            sel0_en_r <= `SSP_CTL_RESET;
            sel1_en_r <= `SSP_CTL_RESET;
            div_r <= `SSP_DIV_RESET;
        end else if (wr_i && addr_i == `SSP_OFF_CONTROL) begin
            // Changing rate or selects mid-transfer is not blocked; software must wait for idle.
            sel0_en_r <= wdata_i[`SSP_CTL_SEL0];
            sel1_en_r <= wdata_i[`SSP_CTL_SEL1];
            div_r <= wdata_i[`SSP_CTL_DIV_HI:`SSP_CTL_DIV_LO];
        end
    end

    // Transmit registers only take a write that starts a transfer, so they read back
    // the word that was last sent.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_one_r <= 8'h00;
        end else if (start_tx && addr_i == `SSP_OFF_TX_ONE) begin
            tx_one_r <= wdata_i[7:0];
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_zero_r <= 8'h00;
        end else if (start_tx && addr_i == `SSP_OFF_TX_ZERO) begin
            tx_zero_r <= wdata_i[7:0];
        end
    end

    // A refused access wins over the deselect clear in the same cycle, so it is never lost.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            coll_r <= 1'b0;
        end else if ((wr_tx || rd_rx) && busy) begin
            coll_r <= 1'b1;
        end else if (!any_sel) begin
            coll_r <= 1'b0;
        end
    end

    // A completing transfer outranks every clear, a status read in the same cycle included.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            done_r <= 1'b0;
        end else if (done_set) begin
            done_r <= 1'b1;
        end else if (rd_rx || wr_tx || rd_stat || !any_sel) begin
            done_r <= 1'b0;
        end
    end

    // ==========================================================
    // Read data
    // ==========================================================
    // Idle cycles and unmapped offsets give zero, so read data of several blocks may be ORed.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                `SSP_OFF_STATUS: rdata_o <= {13'h0000, coll_r, done_r, busy};
                `SSP_OFF_CONTROL: rdata_o <= {`SSP_CTL_RSVD_HI, div_r, 2'h0, sel1_en_r, sel0_en_r};
                `SSP_OFF_TX_ONE: rdata_o <= {8'h00, tx_one_r};
                `SSP_OFF_TX_ZERO: rdata_o <= {8'h00, tx_zero_r};
                `SSP_OFF_RX: rdata_o <= {8'h00, rx_r};
                default: rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

endmodule
`default_nettype wire

// ===== testbench/sync_serial_port_sva.sv
// Checker of the synchronous serial port's pin and register timing.
`timescale 1ns/10ps
`default_nettype none
module sync_serial_port_sva #(
    parameter WORD_BITS = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic periph_select_zero_o,
    input wire logic periph_select_one_o,
    input wire logic shift_clock_o,
    input wire logic shared_data_line_o,
    input wire logic shared_data_line_oe_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // The slowest divider gives a low phase of eight clocks, so a ninth low cycle is a fault.
    sequence s_low_run; !shift_clock_o [*8]; endsequence
    sequence s_ctl; wr_i && addr_i == 8'h12; endsequence
    sequence s_drv_chg; shared_data_line_oe_o && $past(shared_data_line_oe_o) && $changed(shared_data_line_o); endsequence
    sequence s_rx_rd;
        rd_i && addr_i == 8'h18 && (periph_select_zero_o || periph_select_one_o) && !shared_data_line_oe_o;
    endsequence
    AST_SEL_EXCL: assert property (!(periph_select_zero_o && periph_select_one_o)) else $error("two selects");
    AST_SEL_ZERO: assert property (s_ctl ##0 wdata_i[0] |=> periph_select_zero_o) else $error("sel0");
    AST_SEL_ONE: assert property (s_ctl ##0 wdata_i[1:0] == 2'b10 |=> periph_select_one_o) else $error("sel1");
    AST_CLK_BOUND: assert property (s_low_run |=> shift_clock_o) else $error("slow clock");
    AST_DRV_FALL: assert property (s_drv_chg |-> $fell(shift_clock_o)) else $error("data moved");
    AST_START_LOW: assert property ($rose(shared_data_line_oe_o) |-> !shift_clock_o) else $error("start");
    AST_TAIL_HOLD: assert property ($fell(shared_data_line_oe_o) |-> $past(shift_clock_o)) else $error("tail");
    AST_STAT_RSVD: assert property (rd_i && addr_i == 8'h10 |=> rdata_o[15:3] == 13'h0000) else $error("rsvd");
    AST_RX_QUIET: assert property (s_rx_rd |=> !shared_data_line_oe_o [*8]) else $error("rx drive");
endmodule
bind sync_serial_port sync_serial_port_sva #(.WORD_BITS(WORD_BITS)) i_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .periph_select_zero_o(periph_select_zero_o), .periph_select_one_o(periph_select_one_o),
    .shift_clock_o(shift_clock_o), .shared_data_line_o(shared_data_line_o),
    .shared_data_line_oe_o(shared_data_line_oe_o));
`default_nettype wire

// ===== testbench/periph_slave_model.sv
// Peripheral slave on the shared data line, including the line's weak keeper.
`timescale 1ns/10ps
`default_nettype none
module periph_slave_model (
    input wire logic clk_i,
    input wire logic sclk_i,
    input wire logic sel_i,
    input wire logic reply_i,
    input wire logic [7:0] word_i,
    input wire logic m_data_i,
    input wire logic m_oe_i,
    output logic line_o,
    output logic [7:0] got_o
);
    logic [7:0] out_r = 8'h00;
    logic sclk_r = 1'b1;
    logic drv_r = 1'b0;
    logic en_r = 1'b0;
    logic keep_r = 1'b1;
    assign line_o = m_oe_i ? m_data_i : (en_r ? drv_r : keep_r);
    always @(posedge clk_i) begin
        sclk_r <= sclk_i;
        keep_r <= line_o;
        // The reply word is reloaded whenever the slave is not answering, so each read starts at bit 0.
        if (!sel_i || !reply_i) begin
            en_r <= 1'b0;
            out_r <= word_i;
        end else if (sclk_r && !sclk_i) begin
            en_r <= 1'b1;
            drv_r <= out_r[0];
            out_r <= out_r >> 1;
        end
        if (sel_i && !sclk_r && sclk_i) begin
            got_o <= {line_o, got_o[7:1]};
        end
    end
endmodule
`default_nettype wire

// ===== testbench/sync_serial_port_tb.sv
// Self-checking bench of the synchronous serial port with a slave model on its far side.
`timescale 1ns/10ps
`default_nettype none
module sync_serial_port_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic reply = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] word = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [7:0] d, got;
    logic [15:0] rdata, v;
    logic sel0, sel1, sclk, dout, doe, line;
    int failures = 0;
    int checked = 0;
    int n;
    always #2 clk = ~clk;
    sync_serial_port i_dut (.sys_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .periph_select_zero_o(sel0), .periph_select_one_o(sel1), .shift_clock_o(sclk),
        .shared_data_line_i(line), .shared_data_line_o(dout), .shared_data_line_oe_o(doe));
    periph_slave_model i_slave (.clk_i(clk), .sclk_i(sclk), .sel_i(sel0 | sel1), .reply_i(reply), .word_i(word),
        .m_data_i(dout), .m_oe_i(doe), .line_o(line), .got_o(got));
    function automatic logic [15:0] stat(input logic b, input logic dn, input logic c);
        return {13'h0000, c, dn, b};
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One bus cycle, then an idle cycle so no strobe is set twice in one time step.
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] wd);
        addr <= a;
        wdata <= wd;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        v = rdata;
        @(posedge clk);
    endtask
    task automatic rc(input string what, input logic [7:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000);
        chk(what, exp, v);
    endtask
    task automatic conclude;
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #40000;
        failures++;
        conclude();
    end
    initial begin
        void'($urandom(98781));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rc("status", 8'h10, 16'h0000);
        rc("unmapped", 8'h1e, 16'h0000);
        acc(1'b1, 8'h12, 16'h0003);
        chk("sels", 16'h0001, {14'h0000, sel1, sel0});
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            acc(1'b1, 8'h12, {10'h000, k[1:0], 2'b00, k[0], !k[0]});
            acc(1'b1, k[0] ? 8'h14 : 8'h16, {8'h00, d});
            for (n = 0; sclk !== 1'b0 && n < 40; n++) @(posedge clk);
            for (n = 0; sclk === 1'b0 && n < 40; n++) @(posedge clk);
            chk("half period", 16'(1 << k), 16'(n));
            rc("busy", 8'h10, stat(1'b1, 1'b0, 1'b0));
            acc(1'b1, 8'h16, 16'h005a);
            rc("collision", 8'h10, stat(1'b1, 1'b0, 1'b1));
            repeat (16 << k) @(posedge clk);
            rc("done", 8'h10, stat(1'b0, 1'b1, 1'b1));
            rc("done read", 8'h10, stat(1'b0, 1'b0, 1'b1));
            chk("slave word", {8'h00, d}, {8'h00, got});
            acc(1'b1, 8'h12, 16'h0000);
            rc("deselect", 8'h10, 16'h0000);
        end
        word <= 8'($urandom);
        reply <= 1'b1;
        acc(1'b1, 8'h12, 16'h0031);
        rc("control", 8'h12, 16'hfff1);
        acc(1'b0, 8'h18, 16'h0000);
        rc("rx busy", 8'h10, stat(1'b1, 1'b0, 1'b0));
        acc(1'b0, 8'h18, 16'h0000);
        rc("rx coll", 8'h10, stat(1'b1, 1'b0, 1'b1));
        repeat (140) @(posedge clk);
        acc(1'b1, 8'h12, 16'h0030);
        reply <= 1'b0;
        rc("rx idle", 8'h10, 16'h0000);
        rc("rx word", 8'h18, {8'h00, word});
        rc("no start", 8'h10, 16'h0000);
        conclude();
    end
endmodule
`default_nettype wire
